// file: bench/sedc_mem_model.sv
/*
  Behavioural serial memory for the bench.
  Assumes MSB-first frames from the block and a pull-up on the data line.
*/
`timescale 1ns/10ps
module sedc_mem_model (
  // Link pins.
  input  wire logic        sk,
  input  wire logic        cs,
  input  wire logic        di,
  input  wire logic        oe,
  // Fitting: 0 fitted, 1 absent pulled high, 2 absent pulled low.
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] busy_ns,
  output logic             line
);
  logic [7:0] adr; // Address taken in.
  logic [7:0] sh;  // Read shifter.
  logic       rd;  // Memory drives read data.
  logic       wr;  // A full write frame was sent.
  logic       bsy; // Programming in progress.
  int         nbit; // Clock rises in this select.
  // The block wins, then the pull of an absent memory, then the memory.
  assign line = oe ? di : mode == 2'h2 ? 1'b0 : mode != 2'h0 ? 1'b1 : rd ? sh[7] : !bsy;
  // Idle at start.
  initial
  begin
    rd = 1'b0;
    wr = 1'b0;
    bsy = 1'b0;
    nbit = 0;
  end
  // Address bits follow start and opcode; the byte is ready after bit 11.
  always @(posedge sk)
  begin
    if (cs && nbit >= 3 && nbit <= 10)
      adr = {adr[6:0], di};
    nbit = nbit + 1;
    if (cs && nbit == 11)
    begin
      sh = adr == 8'h00 ? 8'hA5 : 8'(adr * 8'h11);
      rd = 1'b1;
    end
  end
  // A driven line means a write frame; else shift, vacated bits toggle.
  always @(negedge sk)
    if (rd && nbit > 11)
    begin
      if (oe)
        rd = 1'b0;
      else
        sh = {sh[6:0], ~sh[7]};
    end
  // Release on deselect and remember a finished write.
  always @(negedge cs)
  begin
    wr = nbit >= 19 && !rd;
    rd = 1'b0;
  end
  // Busy low while programming, seen by the next select.
  always @(posedge cs)
  begin
    nbit = 0;
    if (wr)
    begin
      wr = 1'b0;
      bsy = 1'b1;
      #(busy_ns);
      bsy = 1'b0;
    end
  end
endmodule // sedc_mem_model

// file: bench/sedc_top_tb.sv
/*
  Bench of the command and status block, one task a scenario.
  Assumes the memory model and a shortened time-out.
*/
`timescale 1ns/10ps
module sedc_top_tb;
  localparam int TMO = 4000; // Short time-out in cycles.
  localparam logic [11:0] A_CMD = sedc_pkg::OFF_CMD;
  localparam logic [11:0] A_DAT = sedc_pkg::OFF_DATA;
  // Bus, pins and model settings.
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, sk, cs, dout, oe, line, err;
  logic [47:0] station_addr;
  logic [1:0]  mode = 2'h0;
  logic [15:0] busy_ns = 16'h1388;
  int          n_fail = 0;
  int          checks_done = 0;
  // Clock of 10 ns.
  always #5 pclk = ~pclk;
  sedc_top #(.TMO_CYCLES(TMO)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .eeprom_clk(sk), .eeprom_cs(cs),
    .eeprom_serial_data_line_in(line), .eeprom_serial_data_line_out(dout),
    .eeprom_serial_data_line_oe(oe), .station_addr(station_addr));
  sedc_mem_model mem (.sk(sk), .cs(cs), .di(dout), .oe(oe), .mode(mode),
    .busy_ns(busy_ns), .line(line));
  // Compare and count.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll busy under a bound of reads.
  task automatic cmd(input logic [2:0] op, input logic [7:0] a, input int lim);
    int n;
    n = 0;
    if (lim < 6000)
      apb(1'b1, A_CMD, {1'b1, op, 20'h0, a});
    do
    begin
      apb(1'b0, A_CMD, 32'h0);
      n++;
    end
    while (rd[31] !== 1'b0 && n < lim);
    chk(n < lim, 1'b1);
  endtask
  // Boot load, clearing, reload and an unmapped read.
  task automatic t_boot();
    cmd(3'h0, 8'h00, 6000);
    chk(rd[9:0], 10'h100);
    chk(station_addr, 48'h112233445566);
    apb(1'b1, A_CMD, 32'h100);
    apb(1'b0, A_CMD, 32'h0);
    chk(rd[8], 1'b0);
    apb(1'b1, A_CMD, {1'b1, sedc_pkg::OP_RELOAD, 28'h0});
    cmd(3'h0, 8'h00, 6001);
    chk(rd[9:8], 2'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    $display("TB: boot test done");
  endtask
  // Done event raised, masked, unmasked, cleared.
  task automatic t_irq();
    apb(1'b0, sedc_pkg::OFF_ISTS, 32'h0);
    chk(rd[1:0], 2'h1);
    chk(irq, 1'b0);
    apb(1'b1, sedc_pkg::OFF_IMSK, 32'h1);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, sedc_pkg::OFF_ISTS, 32'h3);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    apb(1'b1, sedc_pkg::OFF_IMSK, 32'h0);
    $display("TB: interrupt test done");
  endtask
  // Reads at a low and the top address.
  task automatic t_read();
    logic [7:0] a;
    for (int i = 0; i < 2; i++)
    begin
      a = i ? 8'hFF : 8'h03;
      cmd(sedc_pkg::OP_READ, a, 1500);
      chk(rd[7:0], a);
      apb(1'b0, A_DAT, 32'h0);
      chk(rd, {24'h0, 8'(a * 8'h11)});
    end
    $display("TB: read test done");
  endtask
  // Enabled write against a slow memory.
  task automatic t_write();
    busy_ns <= 16'h3A98;
    cmd(sedc_pkg::OP_ERASE_WRITE_ENABLE_CMD, 8'h00, 1500);
    apb(1'b1, A_DAT, 32'h5A);
    cmd(sedc_pkg::OP_WRITE, 8'h10, 1500);
    chk(rd[9], 1'b0);
    apb(1'b0, A_DAT, 32'h0);
    chk(rd, 32'h5A);
    $display("TB: write test done");
  endtask
  // Every command with no memory, line pulled high then low.
  task automatic t_absent();
    for (int m = 1; m < 3; m++)
    begin
      mode <= 2'(m);
      for (int i = 0; i < 8; i++)
      begin
        cmd(3'(i), 8'h00, 1500);
        chk(rd[9], m == 2 && i >= 3 && i <= 6);
        apb(1'b1, A_CMD, 32'h200);
      end
    end
    apb(1'b0, sedc_pkg::OFF_ISTS, 32'h0);
    chk(rd[1:0], 2'h3);
    $display("TB: absent memory test done");
  endtask
  // Counts, verdict and end.
  task automatic print_verdict();
    $display("TB: checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence after 5 cycles of reset.
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_boot();
    t_irq();
    t_read();
    t_write();
    t_absent();
    print_verdict();
  end
  // Watchdog at 95,000 cycles; the tests need about 70,000.
  initial
  begin
    #950000;
    n_fail++;
    print_verdict();
  end
endmodule // sedc_top_tb

// file: hdl/sedc_link.sv
/*
  Bit engine of the serial EEPROM link: shifts a frame out, reads a byte
  back or polls the data line for ready. Assumes the data line input comes
  straight from the pin; it passes a two-stage synchroniser here.
*/
`timescale 1ns/10ps
module sedc_link #(
  parameter int HALF = sedc_pkg::SK_HALF_CYC
) (
  // Clock and reset.
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Requests from the sequencer.
  input  wire logic                  start,
  input  wire sedc_pkg::sedc_frame_t frame,
  input  wire logic                  abort,
  // Link pins.
  input  wire logic                  din,
  output logic                       sk,
  output logic                       cs,
  output logic                       dout,
  output logic                       doe,
  // Results.
  output logic                       done,
  output logic [7:0]                 rx_byte
);
  // The divider must fit its 16-bit counter, and the ready poll needs at
  // least four cycles in each half period.
  if (HALF < 4 || HALF > 65535)
  begin : g_chk
    $error("HALF out of range");
  end

  // Engine states.
  typedef enum logic [4:0] {
    E_IDLE = 5'h01, E_TX = 5'h02, E_RX = 5'h04, E_GAP = 5'h08, E_POLL = 5'h10
  } sedc_est_t;

  sedc_est_t                   st_r, st_nxt;     // Engine state.
  logic [15:0]                 div_r, div_nxt;   // Half-period divider.
  logic [sedc_pkg::FRAME_W-1:0] sh_r, sh_nxt;    // Outgoing shift register.
  logic [4:0]                  cnt_r, cnt_nxt;   // Bits left in this phase.
  logic                        rxen_r, rxen_nxt; // A byte follows the frame.
  logic                        wt_r, wt_nxt;     // Poll for ready afterwards.
  logic                        sk_nxt, cs_nxt, dout_nxt, doe_nxt, done_nxt;
  logic [7:0]                  rx_nxt;
  logic                        tick;             // End of a half period.
  logic                        din_s1_r, din_s2_r; // Data line synchroniser.

  assign tick = (div_r == 16'(HALF - 1));

  // Next-state logic; the data changes while the clock is low and the
  // memory samples on the rising edge.
  always_comb
  begin
    st_nxt   = st_r;
    div_nxt  = (st_r == E_IDLE || tick) ? 16'h0000 : div_r + 16'h0001;
    sh_nxt   = sh_r;
    cnt_nxt  = cnt_r;
    rxen_nxt = rxen_r;
    wt_nxt   = wt_r;
    sk_nxt   = sk;
    cs_nxt   = cs;
    dout_nxt = dout;
    doe_nxt  = doe;
    done_nxt = 1'b0;
    rx_nxt   = rx_byte;
    if (abort)
    begin
      // A time-out drops the link at once.
      st_nxt  = E_IDLE;
      sk_nxt  = 1'b0;
      cs_nxt  = 1'b0;
      doe_nxt = 1'b0;
    end
    else
    begin
      unique case (st_r)
        E_IDLE:
          if (start)
          begin
            sh_nxt   = frame.bits;
            cnt_nxt  = frame.len;
            rxen_nxt = frame.rx;
            wt_nxt   = frame.wait_rdy;
            cs_nxt   = 1'b1;
            doe_nxt  = 1'b1;
            dout_nxt = frame.bits[sedc_pkg::FRAME_W-1];
            st_nxt   = E_TX;
          end
        E_TX:
          if (tick && !sk)
            sk_nxt = 1'b1;
          else if (tick)
          begin
            // Falling edge: present the next bit.
            sk_nxt   = 1'b0;
            sh_nxt   = {sh_r[sedc_pkg::FRAME_W-2:0], 1'b0};
            dout_nxt = sh_r[sedc_pkg::FRAME_W-2];
            cnt_nxt  = cnt_r - 5'h01;
            if (cnt_r == 5'h01)
            begin
              doe_nxt  = 1'b0;
              dout_nxt = 1'b0;
              if (rxen_r)
              begin
                cnt_nxt = 5'h08;
                st_nxt  = E_RX;
              end
              else
              begin
                // Without a ready poll the command ends with its frame.
                cs_nxt   = 1'b0;
                done_nxt = !wt_r;
                st_nxt   = wt_r ? E_GAP : E_IDLE;
              end
            end
          end
        E_RX:
          if (tick && !sk)
          begin
            sk_nxt = 1'b1;
            rx_nxt = {rx_byte[6:0], din_s2_r};
          end
          else if (tick)
          begin
            sk_nxt  = 1'b0;
            cnt_nxt = cnt_r - 5'h01;
            if (cnt_r == 5'h01)
            begin
              cs_nxt   = 1'b0;
              done_nxt = 1'b1;
              st_nxt   = E_IDLE;
            end
          end
        E_GAP:
          if (tick)
          begin
            // Select is low for one half period before the ready poll.
            cs_nxt = 1'b1;
            st_nxt = E_POLL;
          end
        E_POLL:
          if (din_s2_r && div_r >= 16'h0003)                                   // RQ3
          begin
            // A high line means ready, or no memory and a pull-up. The first
            // cycles of each half period are skipped so that the synchroniser
            // never hands over the level from before select rose.
            cs_nxt   = 1'b0;
            done_nxt = 1'b1;
            st_nxt   = E_IDLE;
          end
        default:
          st_nxt = E_IDLE;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r    <= E_IDLE;
      div_r   <= 16'h0000;
      sh_r    <= '0;
      cnt_r   <= 5'h00;
      rxen_r  <= 1'b0;
      wt_r    <= 1'b0;
      sk      <= 1'b0;
      cs      <= 1'b0;
      dout    <= 1'b0;
      doe     <= 1'b0;
      done    <= 1'b0;
      rx_byte <= 8'h00;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      div_r   <= div_nxt;
      sh_r    <= sh_nxt;
      cnt_r   <= cnt_nxt;
      rxen_r  <= rxen_nxt;
      wt_r    <= wt_nxt;
      sk      <= sk_nxt;
      cs      <= cs_nxt;
      dout    <= dout_nxt;
      doe     <= doe_nxt;
      done    <= done_nxt;
      rx_byte <= rx_nxt;
      din_s1_r <= din;
      din_s2_r <= din_s1_r;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A high line during the poll finishes the command on the next edge.
  property p_rq3;
    (st_r == E_POLL && din_s2_r && div_r >= 16'h0003 && !abort) |=> (done && !cs) ##1 !done;
  endproperty
  a_rq3: assert property (p_rq3) else $error("ready poll did not finish"); // RQ3
endmodule // sedc_link

// file: hdl/sedc_pkg.sv
/*
  Shared constants and types of the serial EEPROM command and status block.
  Assumes a 100 MHz APB clock.
*/
package sedc_pkg;
  // Clock period and the operation time-out.
  localparam int CLK_NS      = 10;
  localparam int TMO_MS      = 30;
  localparam int TMO_CYC     = TMO_MS * 1000000 / CLK_NS;
  // Half period of the serial clock, rounded up to whole cycles.
  localparam int SK_HALF_NS  = 500;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
  // Register byte offsets.
  localparam logic [11:0] OFF_CMD  = 12'h000;
  localparam logic [11:0] OFF_DATA = 12'h004;
  localparam logic [11:0] OFF_ISTS = 12'h008;
  localparam logic [11:0] OFF_IMSK = 12'h00C;
  // Field positions of the command and status register.
  localparam int BUSY_BIT   = 31;
  localparam int OP_LSB     = 28;
  localparam int TMO_BIT    = 9;
  localparam int LOADED_BIT = 8;
  // Interrupt status and mask bits.
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TMO_BIT  = 1;
  // Reset values, the valid-memory signature byte and the last reload index.
  localparam logic [7:0] ADDR_RST  = 8'h00;
  localparam logic [7:0] DATA_RST  = 8'h00;
  localparam logic [7:0] SIGNATURE = 8'hA5;
  localparam logic [2:0] LAST_IDX  = 3'h6;
  // Width of one serial frame: start bit, opcode, address, data.
  localparam int FRAME_W = 19;
  // Commands as software writes them.
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_EWDS = 3'h1, OP_ERASE_WRITE_ENABLE_CMD = 3'h2, OP_WRITE = 3'h3,
    OP_WRITE_ALL_CMD = 3'h4, OP_ERASE = 3'h5, OP_ERASE_ALL_CMD = 3'h6, OP_RELOAD = 3'h7
  } sedc_op_t;
  // One serial frame with its handling flags.
  typedef struct packed {
    logic [4:0]         len;
    logic [FRAME_W-1:0] bits;
    logic               rx;
    logic               wait_rdy;
  } sedc_frame_t;
endpackage

// file: hdl/sedc_top.sv
/*
  Serial EEPROM command and status block with an APB register slave,
  a command sequencer with time-out, station address reload and interrupt.
  Assumes an APB master on pclk and a data line with external pull.
*/
// Chosen here: the APB interface to the registers and the register addresses.
// How it works
// RQ1 - Abandon operation after 30 ms, go idle
// RQ2 - Time-out sets status bit 9
// RQ3 - Pulled-high line: no time-out, busy clears
// RQ4 - Only erase and write kinds may time out
// RQ5 - Valid memory reload sets bit 8, clearable
// RQ6 - Bits 7-0 address the operation, reset 00h
// RQ7 - Byte register holds read or write data
// RQ8 - Software enables erase/write before erasing or writing
`timescale 1ns/10ps
module sedc_top #(
  parameter int TMO_CYCLES = sedc_pkg::TMO_CYC
) (
  // APB clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt.
  output logic             irq,
  // Serial EEPROM link.
  output logic             eeprom_clk,
  output logic             eeprom_cs,
  input  wire logic        eeprom_serial_data_line_in,
  output logic             eeprom_serial_data_line_out,
  output logic             eeprom_serial_data_line_oe,
  // Station address loaded from the memory.
  output logic [47:0]      station_addr
);
  localparam int TW = $clog2(TMO_CYCLES + 1);
  if (TMO_CYCLES < 2)
  begin : g_chk
    $error("TMO_CYCLES too small");
  end
  // Sequencer states.
  typedef enum logic [2:0] {S_IDLE = 3'h1, S_OP = 3'h2, S_LOAD = 3'h4} sedc_st_t;
  // Builds the serial frame of a command.
  function automatic sedc_pkg::sedc_frame_t make_frame(input sedc_pkg::sedc_op_t op,
                                                       input logic [7:0] a, input logic [7:0] d);
    sedc_pkg::sedc_frame_t f;
    f = '0;
    f.len = 5'h0B;
    unique case (op)
      sedc_pkg::OP_WRITE: begin f.bits = {3'h5, a, d}; f.len = 5'h13; f.wait_rdy = 1'b1; end
      sedc_pkg::OP_ERASE: begin f.bits = {3'h7, a, 8'h00}; f.wait_rdy = 1'b1; end
      sedc_pkg::OP_ERASE_WRITE_ENABLE_CMD:  f.bits = {3'h4, 8'hC0, 8'h00};
      sedc_pkg::OP_EWDS:  f.bits = {3'h4, 8'h00, 8'h00};
      sedc_pkg::OP_WRITE_ALL_CMD:  begin f.bits = {3'h4, 8'h40, d}; f.len = 5'h13; f.wait_rdy = 1'b1; end
      sedc_pkg::OP_ERASE_ALL_CMD:  begin f.bits = {3'h4, 8'h80, 8'h00}; f.wait_rdy = 1'b1; end
      default:            begin f.bits = {3'h6, a, 8'h00}; f.rx = 1'b1; end
    endcase
    return f;
  endfunction
  // One-hot register select; bit 4 marks an unmapped address.
  function automatic logic [4:0] reg_sel(input logic [11:0] a);
    logic [4:0] s;
    unique case (a)
      sedc_pkg::OFF_CMD:  s = 5'h01;
      sedc_pkg::OFF_DATA: s = 5'h02;
      sedc_pkg::OFF_ISTS: s = 5'h04;
      sedc_pkg::OFF_IMSK: s = 5'h08;
      default:            s = 5'h10;
    endcase
    return s;
  endfunction
  sedc_st_t              st_r, st_nxt;           // Sequencer state.
  sedc_pkg::sedc_op_t    op_r, op_nxt;           // Command in progress.
  logic [TW-1:0]         tmo_r, tmo_nxt;         // Time-out counter.
  logic [2:0]            idx_r, idx_nxt;         // Reload byte index.
  logic                  boot_r, boot_nxt;       // Reload pending after reset.
  logic                  start_r, start_nxt;     // Engine start pulse.
  logic                  abort_r, abort_nxt;     // Engine abort pulse.
  sedc_pkg::sedc_frame_t frame_r, frame_nxt;     // Frame handed to the engine.
  logic [7:0]            addr_r, addr_nxt;       // Memory address field.
  logic [7:0]            data_r, data_nxt;       // Byte value register.
  logic                  tmo_flag_r, tmo_flag_nxt; // Time-out status.
  logic                  ld_r, ld_nxt;           // Address loaded status.
  logic [1:0]            ists_r, ists_nxt;       // Interrupt status.
  logic [1:0]            imsk_r, imsk_nxt;       // Interrupt mask.
  logic [47:0]           sta_nxt;
  logic [31:0]           prdata_nxt;
  logic                  pready_nxt, pslverr_nxt, irq_nxt;
  logic                  eng_done, tmo_hit, wr;  // Engine done, time-out, bus write.
  logic [7:0]            eng_rx;                 // Byte read by the engine.
  logic [4:0]            wsel;                   // Register selected by paddr.
  logic [1:0]            ev;                     // Events of this cycle.
  assign tmo_hit = (tmo_r == TW'(TMO_CYCLES - 1));
  assign wr      = psel && penable && pready && pwrite;
  assign wsel    = reg_sel(paddr);
  // Serial bit engine; it passes the raw data line through its own synchroniser.
  sedc_link #(
    .HALF (sedc_pkg::SK_HALF_CYC)
  ) u_link (
    .pclk    (pclk),        .presetn (presetn),
    .start   (start_r),     .frame   (frame_r),
    .abort   (abort_r),     .din     (eeprom_serial_data_line_in),
    .sk      (eeprom_clk),  .cs      (eeprom_cs),
    .dout    (eeprom_serial_data_line_out),
    .doe     (eeprom_serial_data_line_oe),
    .done    (eng_done),    .rx_byte (eng_rx)
  );
  // Sequencer, registers, bus answers and interrupt.
  always_comb
  begin
    st_nxt    = st_r;
    op_nxt    = op_r;
    tmo_nxt   = (st_r == S_IDLE || start_r) ? '0 : tmo_r + TW'(1);
    idx_nxt   = idx_r;
    boot_nxt  = boot_r;
    start_nxt = 1'b0;
    abort_nxt = 1'b0;
    frame_nxt = frame_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    sta_nxt   = station_addr;
    imsk_nxt  = imsk_r;
    ev        = 2'h0;
    tmo_flag_nxt = tmo_flag_r;
    ld_nxt    = ld_r;
    // Software writes come first so that hardware sets win over clears.
    if (wr && wsel[0])
    begin
      tmo_flag_nxt = tmo_flag_r & ~pwdata[sedc_pkg::TMO_BIT];
      ld_nxt       = ld_r & ~pwdata[sedc_pkg::LOADED_BIT];                   // RQ5
      if (st_r == S_IDLE)
        addr_nxt = pwdata[7:0];                                                // RQ6
    end
    if (wr && wsel[1] && st_r == S_IDLE)
      data_nxt = pwdata[7:0];                                                  // RQ7
    ists_nxt = (wr && wsel[2]) ? ists_r & ~pwdata[1:0] : ists_r;
    if (wr && wsel[3])
      imsk_nxt = pwdata[1:0];
    unique case (st_r)
      S_IDLE:
        if (boot_r || (wr && wsel[0] && pwdata[sedc_pkg::BUSY_BIT]))
        begin
          op_nxt    = boot_r ? sedc_pkg::OP_RELOAD
                             : sedc_pkg::sedc_op_t'(pwdata[sedc_pkg::OP_LSB+:3]);
          boot_nxt  = 1'b0;
          start_nxt = 1'b1;
          if (op_nxt == sedc_pkg::OP_RELOAD)
          begin
            idx_nxt   = 3'h0;
            frame_nxt = make_frame(sedc_pkg::OP_READ, 8'h00, 8'h00);
            st_nxt    = S_LOAD;
          end
          else
          begin
            // The frame takes the address written with the command and the byte as it stands now.
            frame_nxt = make_frame(op_nxt, addr_nxt, data_nxt);               // RQ6 RQ4
            st_nxt    = S_OP;
          end
        end
      S_OP, S_LOAD:
        if (eng_done)
        begin
          st_nxt = S_IDLE;
          ev[sedc_pkg::IRQ_DONE_BIT] = 1'b1;
          if (st_r == S_OP && op_r == sedc_pkg::OP_READ)
            data_nxt = eng_rx;                                                 // RQ7
          else if (st_r == S_LOAD && (idx_r != 3'h0 || eng_rx == sedc_pkg::SIGNATURE))
          begin
            if (idx_r != 3'h0)
              sta_nxt = {station_addr[39:0], eng_rx};
            if (idx_r == sedc_pkg::LAST_IDX)
              ld_nxt = 1'b1;                                                   // RQ5
            else
            begin
              idx_nxt   = idx_r + 3'h1;
              frame_nxt = make_frame(sedc_pkg::OP_READ, {5'h00, idx_nxt}, 8'h00);
              start_nxt = 1'b1;
              st_nxt    = S_LOAD;
              ev        = 2'h0;
            end
          end
        end
        else if (tmo_hit)
        begin
          // No answer in time: give up and report it.
          abort_nxt    = 1'b1;                                                 // RQ1
          st_nxt       = S_IDLE;                                               // RQ1
          tmo_flag_nxt = 1'b1;                                                 // RQ2
          ev[sedc_pkg::IRQ_TMO_BIT] = 1'b1;
        end
      default:
        st_nxt = S_IDLE;
    endcase
    ists_nxt = ists_nxt | ev;
    irq_nxt  = |(ists_nxt & imsk_nxt);
    // Read data and error are prepared in the setup cycle.
    pready_nxt  = psel && !penable;
    pslverr_nxt = psel && !penable && wsel[4];
    prdata_nxt  = 32'h0000_0000;
    if (psel && !penable && !pwrite)
      unique case (1'b1)
        wsel[0]: prdata_nxt = {st_r != S_IDLE, op_r, 18'h00000, tmo_flag_r, ld_r, addr_r};
        wsel[1]: prdata_nxt = {24'h000000, data_r};
        wsel[2]: prdata_nxt = {30'h00000000, ists_r};
        wsel[3]: prdata_nxt = {30'h00000000, imsk_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
  end
  // Registers of this block.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r         <= S_IDLE;
      op_r         <= sedc_pkg::OP_READ;
      tmo_r        <= '0;
      idx_r        <= 3'h0;
      boot_r       <= 1'b1;
      start_r      <= 1'b0;
      abort_r      <= 1'b0;
      frame_r      <= '0;
      addr_r       <= sedc_pkg::ADDR_RST;                                      // RQ6
      data_r       <= sedc_pkg::DATA_RST;
      tmo_flag_r   <= 1'b0;
      ld_r         <= 1'b0;
      ists_r       <= 2'h0;
      imsk_r       <= 2'h0;
      station_addr <= 48'h0000_0000_0000;
      prdata       <= 32'h0000_0000;
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      op_r         <= op_nxt;
      tmo_r        <= tmo_nxt;
      idx_r        <= idx_nxt;
      boot_r       <= boot_nxt;
      start_r      <= start_nxt;
      abort_r      <= abort_nxt;
      frame_r      <= frame_nxt;
      addr_r       <= addr_nxt;
      data_r       <= data_nxt;
      tmo_flag_r   <= tmo_flag_nxt;
      ld_r         <= ld_nxt;
      ists_r       <= ists_nxt;
      imsk_r       <= imsk_nxt;
      station_addr <= sta_nxt;
      prdata       <= prdata_nxt;
      pready       <= pready_nxt;
      pslverr      <= pslverr_nxt;
      irq          <= irq_nxt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_tmo;
    (st_r != S_IDLE) && tmo_hit && !eng_done;
  endsequence
  property p_rq1;
    s_tmo |=> (st_r == S_IDLE && abort_r) ##1 !eeprom_cs;
  endproperty
  a_rq1: assert property (p_rq1) else $error("time-out did not abandon"); // RQ1
  property p_rq2;
    s_tmo |=> tmo_flag_r && ists_r[sedc_pkg::IRQ_TMO_BIT];
  endproperty
  a_rq2: assert property (p_rq2) else $error("time-out flag not set"); // RQ2
  property p_rq4;
    start_r && frame_r.wait_rdy |-> op_r inside {sedc_pkg::OP_WRITE, sedc_pkg::OP_WRITE_ALL_CMD,
                                               sedc_pkg::OP_ERASE, sedc_pkg::OP_ERASE_ALL_CMD};
  endproperty
  a_rq4: assert property (p_rq4) else $error("ready poll on wrong command"); // RQ4
  property p_rq5;
    (st_r == S_LOAD && eng_done && idx_r == sedc_pkg::LAST_IDX) |=> ld_r && st_r == S_IDLE;
  endproperty
  a_rq5: assert property (p_rq5) else $error("loaded bit not set"); // RQ5
  property p_rq6;
    start_r && op_r inside {sedc_pkg::OP_READ, sedc_pkg::OP_WRITE, sedc_pkg::OP_ERASE}
      |-> frame_r.bits[15:8] == addr_r;
  endproperty
  a_rq6: assert property (p_rq6) else $error("frame address mismatch"); // RQ6
  property p_rq7;
    (st_r == S_OP && op_r == sedc_pkg::OP_READ && eng_done) |=> data_r == $past(eng_rx);
  endproperty
  a_rq7: assert property (p_rq7) else $error("read byte not stored"); // RQ7
  property p_rq7w;
    (start_r && op_r == sedc_pkg::OP_WRITE) |-> frame_r.bits[7:0] == data_r;
  endproperty
  a_rq7w: assert property (p_rq7w) else $error("write byte mismatch"); // RQ7
endmodule // sedc_top
